// ---- verilog/wwd_pkg.sv ----
// constants, field layout and state record of the windowed watchdog
package wwd_pkg;

  // register map, byte addresses on the register bus
  localparam int unsigned  REG_ADDR_W            = 8;
  localparam logic [7:0]   ADDR_RESTART_COMMAND  = 8'h00;
  localparam logic [7:0]   ADDR_WATCHDOG_SETUP   = 8'h04;
  localparam logic [7:0]   ADDR_FAULT_FLAGS      = 8'h08;

  // restart_command fields
  localparam int unsigned  KEY_MSB               = 31;
  localparam int unsigned  KEY_LSB               = 24;
  localparam logic [7:0]   KEY_VALUE             = 8'hA5;
  localparam int unsigned  RESTART_REQUEST_BIT   = 0;

  // watchdog_setup fields
  localparam int unsigned  LOAD_MSB              = 11;
  localparam int unsigned  LOAD_LSB              = 0;
  localparam int unsigned  FAULT_IRQ_ENABLE_BIT  = 12;
  localparam int unsigned  FAULT_RESET_ENABLE_BIT = 13;
  localparam int unsigned  PROCESSOR_ONLY_BIT    = 14;
  localparam int unsigned  TIMER_DISABLE_BIT     = 15;
  localparam int unsigned  DELTA_MSB             = 27;
  localparam int unsigned  DELTA_LSB             = 16;
  localparam int unsigned  DEBUG_HALT_BIT        = 28;
  localparam int unsigned  IDLE_HALT_BIT         = 29;
  localparam logic [31:0]  SETUP_RESET           = 32'h3FFF_2FFF;
  localparam logic [31:0]  SETUP_WRITABLE        = 32'h3FFF_FFFF;

  // watchdog_fault_flags fields
  localparam int unsigned  UNDERFLOW_FLAG_BIT    = 0;
  localparam int unsigned  WINDOW_ERROR_FLAG_BIT = 1;
  localparam logic [31:0]  FLAGS_RESET           = 32'h0000_0000;

  // counter and prescaler
  localparam int unsigned  COUNT_W               = 12;
  localparam int unsigned  PRESCALE_DIV          = 128;
  localparam int unsigned  PRESCALE_W            = $clog2(PRESCALE_DIV);
  localparam logic [PRESCALE_W-1:0] PRESCALE_LAST = PRESCALE_W'(PRESCALE_DIV - 1);

  // bus answers
  localparam logic [1:0]   RESP_OKAY             = 2'h0;
  localparam logic [1:0]   RESP_SLVERR           = 2'h2;
  localparam logic [3:0]   STRB_ALL              = 4'hF;

  typedef struct packed {
    logic                   awready;
    logic                   wready;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   arready;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
    logic [31:0]            setup;
    logic                   setup_locked;
    logic [COUNT_W-1:0]     count;
    logic [PRESCALE_W-1:0]  prescale;
    logic                   underflow_flag;
    logic                   window_error_flag;
    logic                   fault;
    logic                   irq;
    logic                   processor_only;
  } wwd_state_type;

endpackage

// ---- verilog/wwd_top.sv ----
// windowed watchdog timer with an AXI4-Lite register slave
`timescale 1ns/1ps

module wwd_top
  import wwd_pkg::*;
(
  input  wire logic                  SYS_CLK_I,
  input  wire logic                  RESETN_I,
  input  wire logic                  SLOW_TICK_I,
  input  wire logic                  DEBUG_STATE_I,
  input  wire logic                  IDLE_MODE_I,
  input  wire logic [REG_ADDR_W-1:0] S_AXI_AWADDR_I,
  input  wire logic                  S_AXI_AWVALID_I,
  output wire logic                  S_AXI_AWREADY_O,
  input  wire logic [31:0]           S_AXI_WDATA_I,
  input  wire logic [3:0]            S_AXI_WSTRB_I,
  input  wire logic                  S_AXI_WVALID_I,
  output wire logic                  S_AXI_WREADY_O,
  output wire logic [1:0]            S_AXI_BRESP_O,
  output wire logic                  S_AXI_BVALID_O,
  input  wire logic                  S_AXI_BREADY_I,
  input  wire logic [REG_ADDR_W-1:0] S_AXI_ARADDR_I,
  input  wire logic                  S_AXI_ARVALID_I,
  output wire logic                  S_AXI_ARREADY_O,
  output wire logic [31:0]           S_AXI_RDATA_O,
  output wire logic [1:0]            S_AXI_RRESP_O,
  output wire logic                  S_AXI_RVALID_O,
  input  wire logic                  S_AXI_RREADY_I,
  output wire logic                  IRQ_O,
  output wire logic                  FAULT_O,
  output wire logic                  PROCESSOR_ONLY_O
);

  wwd_state_type s;
  wwd_state_type next_s;

  logic                  wr_fire;
  logic                  rd_fire;
  logic                  full_word;
  logic                  key_ok;
  logic                  restart_request;
  logic                  setup_write;
  logic                  status_read;
  logic                  running;
  logic                  step;
  logic                  underflow_evt;
  logic                  window_error_evt;
  logic                  fault_evt;
  logic [COUNT_W-1:0]    counter_load_value;
  logic [COUNT_W-1:0]    restart_window_delta;
  logic                  fault_irq_enable;
  logic                  fault_reset_enable;
  logic                  processor_only_reset;
  logic                  timer_disable;
  logic                  debug_halt;
  logic                  idle_halt;
  logic [31:0]           setup_written;
  logic                  reload;
  logic [COUNT_W-1:0]    reload_value;
  logic [31:0]           setup_word;
  logic [31:0]           flags_word;

  always_comb begin
    next_s = s;

    // setup fields as currently held
    counter_load_value   = s.setup[LOAD_MSB:LOAD_LSB];
    restart_window_delta = s.setup[DELTA_MSB:DELTA_LSB];
    fault_irq_enable     = s.setup[FAULT_IRQ_ENABLE_BIT];
    fault_reset_enable   = s.setup[FAULT_RESET_ENABLE_BIT];
    processor_only_reset = s.setup[PROCESSOR_ONLY_BIT];
    timer_disable        = s.setup[TIMER_DISABLE_BIT];
    debug_halt           = s.setup[DEBUG_HALT_BIT];
    idle_halt            = s.setup[IDLE_HALT_BIT];

    // rebuilt field by field so the unused top bits can never be stored
    setup_written                                = 32'h0000_0000;
    setup_written[LOAD_MSB:LOAD_LSB]             = S_AXI_WDATA_I[LOAD_MSB:LOAD_LSB];
    setup_written[FAULT_IRQ_ENABLE_BIT]          = S_AXI_WDATA_I[FAULT_IRQ_ENABLE_BIT];
    setup_written[FAULT_RESET_ENABLE_BIT]        = S_AXI_WDATA_I[FAULT_RESET_ENABLE_BIT];
    setup_written[PROCESSOR_ONLY_BIT]            = S_AXI_WDATA_I[PROCESSOR_ONLY_BIT];
    setup_written[TIMER_DISABLE_BIT]             = S_AXI_WDATA_I[TIMER_DISABLE_BIT];
    setup_written[DELTA_MSB:DELTA_LSB]           = S_AXI_WDATA_I[DELTA_MSB:DELTA_LSB];
    setup_written[DEBUG_HALT_BIT]                = S_AXI_WDATA_I[DEBUG_HALT_BIT];
    setup_written[IDLE_HALT_BIT]                 = S_AXI_WDATA_I[IDLE_HALT_BIT];

    // read-back images of the setup and flag registers
    setup_word                                   = 32'h0000_0000;
    setup_word[LOAD_MSB:LOAD_LSB]                = counter_load_value;
    setup_word[FAULT_IRQ_ENABLE_BIT]             = fault_irq_enable;
    setup_word[FAULT_RESET_ENABLE_BIT]           = fault_reset_enable;
    setup_word[PROCESSOR_ONLY_BIT]               = processor_only_reset;
    setup_word[TIMER_DISABLE_BIT]                = timer_disable;
    setup_word[DELTA_MSB:DELTA_LSB]              = restart_window_delta;
    setup_word[DEBUG_HALT_BIT]                   = debug_halt;
    setup_word[IDLE_HALT_BIT]                    = idle_halt;

    flags_word                                   = FLAGS_RESET;
    flags_word[UNDERFLOW_FLAG_BIT]               = s.underflow_flag;
    flags_word[WINDOW_ERROR_FLAG_BIT]            = s.window_error_flag;

    // ready is raised one cycle after both channels are offered; master holds them
    wr_fire   = s.awready && S_AXI_AWVALID_I && S_AXI_WVALID_I;
    rd_fire   = s.arready && S_AXI_ARVALID_I;
    // byte-lane writes would half-apply a keyed command, so only whole words count
    full_word = (S_AXI_WSTRB_I == STRB_ALL);
    key_ok    = (S_AXI_WDATA_I[KEY_MSB:KEY_LSB] == KEY_VALUE);

    restart_request = 1'b0;
    if (wr_fire && full_word && key_ok) begin
      if (S_AXI_AWADDR_I == ADDR_RESTART_COMMAND) begin
        restart_request = S_AXI_WDATA_I[RESTART_REQUEST_BIT];
      end
    end

    setup_write = 1'b0;
    if (wr_fire && full_word && !s.setup_locked) begin
      if (S_AXI_AWADDR_I == ADDR_WATCHDOG_SETUP) begin
        setup_write = 1'b1;
      end
    end

    status_read = 1'b0;
    if (rd_fire && (S_AXI_ARADDR_I == ADDR_FAULT_FLAGS)) begin
      status_read = 1'b1;
    end

    // write channels
    next_s.awready = 1'b0;
    next_s.wready  = 1'b0;
    // both channels must be offered, and no answer may be pending
    if (S_AXI_AWVALID_I && S_AXI_WVALID_I) begin
      if (!s.bvalid && !s.awready) begin
        next_s.awready = 1'b1;
        next_s.wready  = 1'b1;
      end
    end
    if (s.bvalid && S_AXI_BREADY_I) begin
      next_s.bvalid = 1'b0;
    end
    if (wr_fire) begin
      next_s.bvalid = 1'b1;
      case (S_AXI_AWADDR_I)
        ADDR_RESTART_COMMAND: begin
          next_s.bresp = RESP_OKAY;
        end
        ADDR_WATCHDOG_SETUP: begin
          // a locked setup still answers okay, the data is dropped
          next_s.bresp = RESP_OKAY;
        end
        ADDR_FAULT_FLAGS: begin
          // read-only: accepted and ignored
          next_s.bresp = RESP_OKAY;
        end
        default: begin
          next_s.bresp = RESP_SLVERR;
        end
      endcase
    end

    // read channels
    next_s.arready = 1'b0;
    if (S_AXI_ARVALID_I) begin
      if (!s.rvalid && !s.arready) begin
        next_s.arready = 1'b1;
      end
    end
    if (s.rvalid && S_AXI_RREADY_I) begin
      next_s.rvalid = 1'b0;
    end
    if (rd_fire) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = RESP_OKAY;
      case (S_AXI_ARADDR_I)
        ADDR_RESTART_COMMAND: begin
          next_s.rdata = 32'h0000_0000;
        end
        ADDR_WATCHDOG_SETUP: begin
          next_s.rdata = setup_word;
        end
        ADDR_FAULT_FLAGS: begin
          // old flags go out while the same edge clears them
          next_s.rdata = flags_word;
        end
        default: begin
          next_s.rdata = 32'h0000_0000;
          next_s.rresp = RESP_SLVERR;
        end
      endcase
    end

    // counting: halts gate the prescaler, so a halted timer keeps its phase
    // the halt inputs are levels; no debounce, they are taken as synchronous
    running = 1'b1;
    if (timer_disable) begin
      running = 1'b0;
    end
    if (debug_halt && DEBUG_STATE_I) begin
      running = 1'b0;
    end
    if (idle_halt && IDLE_MODE_I) begin
      running = 1'b0;
    end

    step = 1'b0;
    if (running && SLOW_TICK_I && (s.prescale == PRESCALE_LAST)) begin
      step = 1'b1;
    end
    underflow_evt = 1'b0;
    if (step && (s.count == '0)) begin
      underflow_evt = 1'b1;
    end
    if (running && SLOW_TICK_I) begin
      next_s.prescale = s.prescale + 1'b1;
    end
    if (step) begin
      if (underflow_evt) begin
        // count starts over so the fault repeats each period
        next_s.count = counter_load_value;
      end else begin
        next_s.count = s.count - 1'b1;
      end
    end

    // window check applies even with the timer disabled
    window_error_evt = 1'b0;
    if (restart_request) begin
      if (s.count > restart_window_delta) begin
        window_error_evt = 1'b1;
      end
    end

    // one reload path for both restart and setup write
    reload       = 1'b0;
    reload_value = counter_load_value;
    if (restart_request && !window_error_evt) begin
      reload       = 1'b1;
      reload_value = counter_load_value;
    end
    if (setup_write) begin
      next_s.setup        = setup_written;
      next_s.setup_locked = 1'b1;
      reload              = 1'b1;
      reload_value        = setup_written[LOAD_MSB:LOAD_LSB];
    end
    if (reload) begin
      // prescaler restarts too, so the first step is a full period away
      next_s.count    = reload_value;
      next_s.prescale = '0;
    end

    // sticky flags: a new event in the read cycle survives the clear
    fault_evt = underflow_evt || window_error_evt;
    if (status_read) begin
      next_s.underflow_flag    = 1'b0;
      next_s.window_error_flag = 1'b0;
      next_s.irq               = 1'b0;
      next_s.fault             = 1'b0;
    end
    if (underflow_evt) begin
      next_s.underflow_flag = 1'b1;
    end
    if (window_error_evt) begin
      next_s.window_error_flag = 1'b1;
    end
    if (fault_evt && fault_irq_enable) begin
      next_s.irq = 1'b1;
    end
    if (fault_evt && fault_reset_enable) begin
      next_s.fault = 1'b1;
    end
    if (fault_evt && fault_reset_enable) begin
      next_s.processor_only = processor_only_reset;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RESETN_I) begin
      s.awready           <= 1'b0;
      s.wready            <= 1'b0;
      s.bvalid            <= 1'b0;
      s.arready           <= 1'b0;
      s.rvalid            <= 1'b0;
      s.rdata             <= 32'h0000_0000;
      s.bresp             <= RESP_OKAY;
      s.rresp             <= RESP_OKAY;
      s.setup             <= SETUP_RESET;
      s.setup_locked      <= 1'b0;
      s.count             <= SETUP_RESET[LOAD_MSB:LOAD_LSB];
      s.prescale          <= '0;
      s.underflow_flag    <= 1'b0;
      s.window_error_flag <= 1'b0;
      s.fault             <= 1'b0;
      s.irq               <= 1'b0;
      s.processor_only    <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  // all outputs straight from the state record
  assign S_AXI_AWREADY_O  = s.awready;
  assign S_AXI_WREADY_O   = s.wready;
  assign S_AXI_BRESP_O    = s.bresp;
  assign S_AXI_BVALID_O   = s.bvalid;
  assign S_AXI_ARREADY_O  = s.arready;
  assign S_AXI_RDATA_O    = s.rdata;
  assign S_AXI_RRESP_O    = s.rresp;
  assign S_AXI_RVALID_O   = s.rvalid;

  // watchdog lines: irq and fault sticky until a status read or reset, processor_only held until reset or the next fault
  assign IRQ_O            = s.irq;
  assign FAULT_O          = s.fault;
  assign PROCESSOR_ONLY_O = s.processor_only;

endmodule // wwd_top

// ---- bench/wwd_asserts.sv ----
// bus and fault-line properties of the windowed watchdog
`timescale 1ns/1ps
module wwd_asserts
  import wwd_pkg::*;
(
  input wire logic                  SYS_CLK_I,
  input wire logic                  RESETN_I,
  input wire logic                  S_AXI_AWREADY_O,
  input wire logic                  S_AXI_WREADY_O,
  input wire logic                  S_AXI_BVALID_O,
  input wire logic                  S_AXI_BREADY_I,
  input wire logic [1:0]            S_AXI_BRESP_O,
  input wire logic [REG_ADDR_W-1:0] S_AXI_ARADDR_I,
  input wire logic                  S_AXI_ARREADY_O,
  input wire logic                  S_AXI_RVALID_O,
  input wire logic                  S_AXI_RREADY_I,
  input wire logic [31:0]           S_AXI_RDATA_O,
  input wire logic [1:0]            S_AXI_RRESP_O,
  input wire logic                  IRQ_O,
  input wire logic                  FAULT_O
);
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RESETN_I);
  // a status read taken at this edge
  wire logic rd_flags = S_AXI_ARREADY_O && (S_AXI_ARADDR_I == ADDR_FAULT_FLAGS);
  property p_pair; S_AXI_AWREADY_O |-> S_AXI_WREADY_O; endproperty
  a_pair: assert property (p_pair) else $error("write channels readied apart");
  property p_bans; S_AXI_AWREADY_O |-> ##1 (S_AXI_BVALID_O && !S_AXI_AWREADY_O); endproperty
  a_bans: assert property (p_bans) else $error("write answer late");
  property p_bhold; S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O); endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_rans; S_AXI_ARREADY_O |=> S_AXI_RVALID_O; endproperty
  a_rans: assert property (p_rans) else $error("read answer late");
  property p_rhold; S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O); endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  property p_clr; rd_flags |=> !IRQ_O && !FAULT_O; endproperty
  a_clr: assert property (p_clr) else $error("status read left fault up");
  property p_irq; IRQ_O && !rd_flags |=> IRQ_O; endproperty
  a_irq: assert property (p_irq) else $error("interrupt not sticky");
  property p_flt; FAULT_O && !rd_flags |=> FAULT_O; endproperty
  a_flt: assert property (p_flt) else $error("fault not sticky");
  c_irq: cover property ($rose(IRQ_O));
  c_flt: cover property ($rose(FAULT_O));
  c_err: cover property (S_AXI_RVALID_O && S_AXI_RRESP_O == RESP_SLVERR);
endmodule // wwd_asserts

bind wwd_top wwd_asserts u_wwd_asserts (.*);

// ---- bench/wwd_top_bench.sv ----
// self-checking bench for the windowed watchdog
`timescale 1ns/1ps
module wwd_top_bench import wwd_pkg::*;;
  logic SYS_CLK_I = 0, RESETN_I = 0, SLOW_TICK_I = 0, DEBUG_STATE_I = 0, IDLE_MODE_I = 0;
  logic S_AXI_AWVALID_I = 0, S_AXI_WVALID_I = 0, S_AXI_BREADY_I = 0;
  logic S_AXI_ARVALID_I = 0, S_AXI_RREADY_I = 0;
  logic [7:0] S_AXI_AWADDR_I = 0, S_AXI_ARADDR_I = 0;
  logic [31:0] S_AXI_WDATA_I = 0;
  logic [3:0] S_AXI_WSTRB_I = STRB_ALL;
  wire logic S_AXI_AWREADY_O, S_AXI_WREADY_O, S_AXI_BVALID_O, S_AXI_ARREADY_O;
  wire logic S_AXI_RVALID_O, IRQ_O, FAULT_O, PROCESSOR_ONLY_O;
  wire logic [1:0] S_AXI_BRESP_O, S_AXI_RRESP_O;
  wire logic [31:0] S_AXI_RDATA_O;
  int fails = 0, checks_done = 0, t = 0;
  logic [31:0] m_setup;
  logic m_lock;
  always #5 SYS_CLK_I = ~SYS_CLK_I;
  wwd_top u_wwd_top (.*);
  task automatic close_out();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // a hung handshake ends the run
  task automatic to(input int n);
    if (n >= 99) begin
      fails++;
      $display("[ERR] handshake exp 1 got 0");
      close_out();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge SYS_CLK_I);
    S_AXI_AWADDR_I <= a;
    S_AXI_WDATA_I <= d;
    S_AXI_AWVALID_I <= 1;
    S_AXI_WVALID_I <= 1;
    S_AXI_BREADY_I <= 1;
    do @(posedge SYS_CLK_I); while (S_AXI_AWREADY_O !== 1'b1 && ++n < 99);
    S_AXI_AWVALID_I <= 0;
    S_AXI_WVALID_I <= 0;
    do @(posedge SYS_CLK_I); while (S_AXI_BVALID_O !== 1'b1 && ++n < 99);
    S_AXI_BREADY_I <= 0;
    to(n);
    chk("bresp", RESP_OKAY, S_AXI_BRESP_O);
    if (a == ADDR_WATCHDOG_SETUP && !m_lock) begin
      m_setup = d & SETUP_WRITABLE;
      m_lock = 1;
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    int n;
    n = 0;
    @(posedge SYS_CLK_I);
    S_AXI_ARADDR_I <= a;
    S_AXI_ARVALID_I <= 1;
    S_AXI_RREADY_I <= 1;
    do @(posedge SYS_CLK_I); while (S_AXI_ARREADY_O !== 1'b1 && ++n < 99);
    S_AXI_ARVALID_I <= 0;
    do @(posedge SYS_CLK_I); while (S_AXI_RVALID_O !== 1'b1 && ++n < 99);
    S_AXI_RREADY_I <= 0;
    to(n);
    chk("rdata", e, S_AXI_RDATA_O);
    chk("rresp", (a > ADDR_FAULT_FLAGS) ? RESP_SLVERR : RESP_OKAY, S_AXI_RRESP_O);
  endtask
  // slow-clock pulses, one cycle high then one low
  task automatic tick(input int k);
    repeat (k) begin
      @(posedge SYS_CLK_I);
      SLOW_TICK_I <= 1;
      @(posedge SYS_CLK_I);
      SLOW_TICK_I <= 0;
    end
  endtask
  task automatic rst();
    @(posedge SYS_CLK_I);
    RESETN_I <= 0;
    repeat (20) @(posedge SYS_CLK_I);
    RESETN_I <= 1;
    m_setup = SETUP_RESET;
    m_lock = 0;
  endtask
  task automatic endt();
    t++;
    $display("test %0d done, fails %0d", t, fails);
  endtask
  initial begin
    void'($urandom(32'hed2f_a5e9));
    rst();
    rd(ADDR_WATCHDOG_SETUP, m_setup);
    rd(ADDR_FAULT_FLAGS, FLAGS_RESET);
    rd(8'h0C, 32'h0000_0000);
    endt();
    wr(ADDR_WATCHDOG_SETUP, 32'h0001_7003);
    wr(ADDR_WATCHDOG_SETUP, $urandom());
    rd(ADDR_WATCHDOG_SETUP, m_setup);
    wr(ADDR_RESTART_COMMAND, {KEY_VALUE ^ 8'($urandom_range(1, 255)), 24'h00_0001});
    wr(ADDR_RESTART_COMMAND, {KEY_VALUE, 24'h00_0000});
    rd(ADDR_FAULT_FLAGS, 32'h0000_0000);
    wr(ADDR_RESTART_COMMAND, {KEY_VALUE, 24'h00_0001});
    repeat (2) @(posedge SYS_CLK_I);
    chk("irq", 1, IRQ_O);
    chk("fault", 1, FAULT_O);
    chk("scope", 1, PROCESSOR_ONLY_O);
    rd(ADDR_FAULT_FLAGS, 32'h0000_0002);
    repeat (2) @(posedge SYS_CLK_I);
    chk("irq", 0, IRQ_O);
    chk("fault", 0, FAULT_O);
    rd(ADDR_FAULT_FLAGS, 32'h0000_0000);
    endt();
    // load 3: underflow on the fourth prescaler wrap
    tick(511);
    rd(ADDR_FAULT_FLAGS, 32'h0000_0000);
    tick(1);
    rd(ADDR_FAULT_FLAGS, 32'h0000_0001);
    endt();
    rst();
    wr(ADDR_WATCHDOG_SETUP, 32'h3FFF_2000);
    DEBUG_STATE_I <= 1;
    tick(200);
    DEBUG_STATE_I <= 0;
    IDLE_MODE_I <= 1;
    tick(200);
    IDLE_MODE_I <= 0;
    rd(ADDR_FAULT_FLAGS, 32'h0000_0000);
    tick(100);
    wr(ADDR_RESTART_COMMAND, {KEY_VALUE, 24'h00_0001});
    tick(127);
    rd(ADDR_FAULT_FLAGS, 32'h0000_0000);
    tick(1);
    repeat (2) @(posedge SYS_CLK_I);
    chk("irq", 0, IRQ_O);
    chk("fault", 1, FAULT_O);
    chk("scope", 0, PROCESSOR_ONLY_O);
    rd(ADDR_FAULT_FLAGS, 32'h0000_0001);
    endt();
    rst();
    wr(ADDR_WATCHDOG_SETUP, 32'h0FFF_8000);
    tick(300);
    rd(ADDR_FAULT_FLAGS, 32'h0000_0000);
    endt();
    close_out();
  end
endmodule // wwd_top_bench
